// ===== logic/eqf_regs.svh
`ifndef EQF_REGS_SVH
`define EQF_REGS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define EQF_TAP4_IDX        14'h041E
`define EQF_CENTER_IDX      14'h0420
`define EQF_TAP6_IDX        14'h0423
`define EQF_TAP7_IDX        14'h0425
`define EQF_TAP8_IDX        14'h0427
`define EQF_TAP4_ADDR       ({`EQF_TAP4_IDX, 2'b00})
`define EQF_CENTER_ADDR     ({`EQF_CENTER_IDX, 2'b00})
`define EQF_TAP6_ADDR       ({`EQF_TAP6_IDX, 2'b00})
`define EQF_TAP7_ADDR       ({`EQF_TAP7_IDX, 2'b00})
`define EQF_TAP8_ADDR       ({`EQF_TAP8_IDX, 2'b00})

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define EQF_COEF_W          12
`define EQF_COEF_MSB        11
`define EQF_CENTER_W        18
`define EQF_CENTER_MSB      17
`define EQF_NUM_TAPS        9
`define EQF_COEF_RST        12'h000
`define EQF_CENTER_RST      18'h0_0000

`endif

// ===== logic/eqf_pkg.sv
`default_nettype none

package eqf_pkg;

    // Register select, one-hot
    typedef enum logic [5:0] {
        SEL_NONE   = 6'b00_0001,
        SEL_TAP4   = 6'b00_0010,
        SEL_CENTER = 6'b00_0100,
        SEL_TAP6   = 6'b00_1000,
        SEL_TAP7   = 6'b01_0000,
        SEL_TAP8   = 6'b10_0000
    } eqf_sel_t;

    // Coefficients held by this bank
    typedef struct packed {
        logic signed [11:0] tap4;
        logic signed [17:0] center;
        logic signed [11:0] tap6;
        logic signed [11:0] tap7;
        logic signed [11:0] tap8;
    } eqf_coef_bank_t;

endpackage : eqf_pkg

`default_nettype wire

// ===== logic/eqf_coef_bank.sv
// What this block does
// - Fourth tap: 12-bit signed, bits 11:0
// - Center tap: 18-bit signed in 32-bit register
// - Sixth tap register drives sixth filter tap
// - Seventh tap register drives seventh filter tap
// - Single-channel mode uses same tap mapping
// - Readback forces coefficient field MSB to zero
// - Eighth tap register drives eighth filter tap
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "eqf_regs.svh"

module eqf_coef_bank #(
    parameter int SAMPLE_W = 12
) (
    // Clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       srst,
    // AHB-Lite slave
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic                            hreadyout,
    output logic [31:0]                     hrdata,
    output logic                            hresp,
    // Mode and coefficients held elsewhere
    input  wire logic                       single_chan_mode,
    input  wire logic [2:0][11:0]           lower_taps,
    input  wire logic [11:0]                tap9_coef,
    // Sample stream
    input  wire logic                       sample_valid,
    input  wire logic signed [SAMPLE_W-1:0] sample_in,
    // Results
    output eqf_pkg::eqf_coef_bank_t         coef,
    output logic                            fir_valid,
    output logic signed [SAMPLE_W+21:0]     fir_out
);

    localparam int OUT_W = SAMPLE_W + `EQF_CENTER_W + 4;

    if (SAMPLE_W < 2 || SAMPLE_W > 24) begin : g_bad_width
        $error("SAMPLE_W must lie between 2 and 24");
    end

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic eqf_pkg::eqf_sel_t decode(input logic [31:0] a);
        if (a[31:16] != 16'h0000) begin
            return eqf_pkg::SEL_NONE;
        end
        case (a[15:0])
            `EQF_TAP4_ADDR:   return eqf_pkg::SEL_TAP4;
            `EQF_CENTER_ADDR: return eqf_pkg::SEL_CENTER;
            `EQF_TAP6_ADDR:   return eqf_pkg::SEL_TAP6;
            `EQF_TAP7_ADDR:   return eqf_pkg::SEL_TAP7;
            `EQF_TAP8_ADDR:   return eqf_pkg::SEL_TAP8;
            default:          return eqf_pkg::SEL_NONE;
        endcase
    endfunction : decode

    // Readback of a 12-bit field with its top bit cleared
    function automatic logic [31:0] rd12(input logic [11:0] v);
        return {20'h0_0000, 1'b0, v[`EQF_COEF_MSB-1:0]};
    endfunction : rd12

    logic               addr_phase;
    eqf_pkg::eqf_sel_t  addr_sel;
    eqf_pkg::eqf_sel_t  wr_sel;
    logic               wr_pend;
    logic               wr_hit;
    logic [11:0]        next_tap4;
    logic [17:0]        next_center;
    logic [11:0]        next_tap6;
    logic [11:0]        next_tap7;
    logic [11:0]        next_tap8;
    logic [31:0]        next_rdata;

    assign addr_phase = hsel && htrans[1] && hready;
    assign addr_sel   = decode(haddr);
    assign wr_hit     = wr_pend && hready;

    // ****************************************************************
    // Coefficient write path
    // ****************************************************************
    assign next_tap4   = (wr_hit && wr_sel == eqf_pkg::SEL_TAP4) ? hwdata[11:0] : coef.tap4;
    assign next_center = (wr_hit && wr_sel == eqf_pkg::SEL_CENTER) ? hwdata[17:0] : coef.center;
    assign next_tap6   = (wr_hit && wr_sel == eqf_pkg::SEL_TAP6) ? hwdata[11:0] : coef.tap6;
    assign next_tap7   = (wr_hit && wr_sel == eqf_pkg::SEL_TAP7) ? hwdata[11:0] : coef.tap7;
    assign next_tap8   = (wr_hit && wr_sel == eqf_pkg::SEL_TAP8) ? hwdata[11:0] : coef.tap8;

    // Read mux looks at next values so a read right after a write sees it
    assign next_rdata =
        (addr_sel == eqf_pkg::SEL_TAP4)   ? rd12(next_tap4) :
        (addr_sel == eqf_pkg::SEL_CENTER) ? {14'h0000, 1'b0, next_center[`EQF_CENTER_MSB-1:0]} :
        (addr_sel == eqf_pkg::SEL_TAP6)   ? rd12(next_tap6) :
        (addr_sel == eqf_pkg::SEL_TAP7)   ? rd12(next_tap7) :
        (addr_sel == eqf_pkg::SEL_TAP8)   ? rd12(next_tap8) : 32'h0000_0000;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wr_pend   <= 1'b0;
            wr_sel    <= eqf_pkg::SEL_NONE;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
            coef      <= '{`EQF_COEF_RST, `EQF_CENTER_RST, `EQF_COEF_RST, `EQF_COEF_RST, `EQF_COEF_RST};
        end else begin
            if (hready) begin
                wr_pend <= addr_phase && hwrite;
                wr_sel  <= addr_sel;
                hrdata  <= (addr_phase && !hwrite) ? next_rdata : 32'h0000_0000;
            end
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            coef      <= '{next_tap4, next_center, next_tap6, next_tap7, next_tap8};
        end
    end

    // ****************************************************************
    // Nine-tap filter datapath
    // ****************************************************************
    // Tap order is fixed; mode does not remap registers to taps
    logic signed [17:0]         taps   [`EQF_NUM_TAPS];
    logic signed [SAMPLE_W-1:0] window [`EQF_NUM_TAPS];
    logic signed [SAMPLE_W-1:0] hist   [`EQF_NUM_TAPS-1];
    logic signed [OUT_W-1:0]    next_sum;

    genvar gi;
    for (gi = 0; gi < 3; gi++) begin : g_lower
        assign taps[gi] = 18'(signed'(lower_taps[gi]));
    end
    assign taps[3] = 18'(coef.tap4);
    assign taps[4] = coef.center;
    assign taps[5] = 18'(coef.tap6);
    assign taps[6] = 18'(coef.tap7);
    assign taps[7] = 18'(coef.tap8);
    assign taps[8] = 18'(signed'(tap9_coef));

    assign window[0] = sample_in;
    for (gi = 1; gi < `EQF_NUM_TAPS; gi++) begin : g_window
        assign window[gi] = hist[gi-1];
    end

    always_comb begin
        next_sum = '0;
        for (int k = 0; k < `EQF_NUM_TAPS; k++) begin
            next_sum = OUT_W'(next_sum + OUT_W'(window[k] * taps[k]));
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            fir_valid <= 1'b0;
            fir_out   <= '0;
            for (int k = 0; k < `EQF_NUM_TAPS - 1; k++) begin
                hist[k] <= '0;
            end
        end else begin
            fir_valid <= sample_valid;
            if (sample_valid) begin
                fir_out <= next_sum;
                for (int k = 0; k < `EQF_NUM_TAPS - 1; k++) begin
                    hist[k] <= window[k];
                end
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    logic hist_zero;
    always_comb begin
        hist_zero = 1'b1;
        for (int k = 0; k < `EQF_NUM_TAPS - 1; k++) begin
            hist_zero = hist_zero && (hist[k] == '0);
        end
    end

    tap4_write_a: assert property (
        wr_hit && wr_sel == eqf_pkg::SEL_TAP4 |=> coef.tap4 == $past(hwdata[11:0]))
        else $error("tap4 coefficient not written");
    center_write_a: assert property (
        wr_hit && wr_sel == eqf_pkg::SEL_CENTER |=> coef.center == $past(hwdata[17:0]))
        else $error("center coefficient not written");
    tap6_write_a: assert property (
        wr_hit && wr_sel == eqf_pkg::SEL_TAP6 |=> coef.tap6 == $past(hwdata[11:0]))
        else $error("tap6 coefficient not written");
    tap7_write_a: assert property (
        wr_hit && wr_sel == eqf_pkg::SEL_TAP7 |=> coef.tap7 == $past(hwdata[11:0]))
        else $error("tap7 coefficient not written");
    tap8_write_a: assert property (
        wr_hit && wr_sel == eqf_pkg::SEL_TAP8 |=> coef.tap8 == $past(hwdata[11:0]))
        else $error("tap8 coefficient not written");
    mode_stable_a: assert property (!wr_hit && $changed(single_chan_mode) |=> $stable(coef))
        else $error("coefficients moved on mode change");
    read_msb_a: assert property (
        addr_phase && !hwrite && addr_sel != eqf_pkg::SEL_NONE
        |=> ((wr_sel == eqf_pkg::SEL_CENTER) ? (hrdata[31:17] == 15'h0000) : (hrdata[31:11] == 21'h00_0000)))
        else $error("readback msb not zero");
    impulse_a: assert property (
        sample_valid && hist_zero && sample_in == SAMPLE_W'(1)
        |=> fir_valid && fir_out == OUT_W'($past(taps[0])))
        else $error("impulse response wrong");

    write_read_c:  cover property (wr_hit ##1 addr_phase && !hwrite);
    center_neg_c:  cover property (wr_hit && wr_sel == eqf_pkg::SEL_CENTER && hwdata[17]);
    filter_run_c:  cover property (sample_valid [*3]);
    single_mode_c: cover property (single_chan_mode && sample_valid);

endmodule : eqf_coef_bank

`default_nettype wire

// ===== dv/eqf_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "eqf_regs.svh"

module testbench;
    logic                    core_clk = 1'b0;
    logic                    srst = 1'b1;
    logic                    hsel = 1'b0;
    logic [31:0]             haddr = 32'h0;
    logic [1:0]              htrans = 2'h0;
    logic                    hwrite = 1'b0;
    logic [2:0]              hsize = 3'h2;
    logic [31:0]             hwdata = 32'h0;
    wire logic               hready;
    logic [31:0]             hrdata;
    logic                    hresp;
    logic                    single_chan_mode = 1'b0;
    logic [2:0][11:0]        lower_taps = 36'h0;
    logic [11:0]             tap9_coef = 12'h0;
    logic                    sample_valid = 1'b0;
    logic signed [11:0]      sample_in = 12'h0;
    eqf_pkg::eqf_coef_bank_t coef;
    logic                    fir_valid;
    logic signed [33:0]      fir_out;
    logic [31:0]             seed = 32'h22;
    logic [31:0]             addr [5];
    logic [17:0]             exp_f [5];
    int                      bad_count = 0;
    int                      checks = 0;

    always #2 core_clk = ~core_clk;

    eqf_coef_bank uut (
        .core_clk         (core_clk),
        .srst             (srst),
        .hsel             (hsel),
        .haddr            (haddr),
        .htrans           (htrans),
        .hwrite           (hwrite),
        .hsize            (hsize),
        .hwdata           (hwdata),
        .hready           (hready),
        .hreadyout        (hready),
        .hrdata           (hrdata),
        .hresp            (hresp),
        .single_chan_mode (single_chan_mode),
        .lower_taps       (lower_taps),
        .tap9_coef        (tap9_coef),
        .sample_valid     (sample_valid),
        .sample_in        (sample_in),
        .coef             (coef),
        .fir_valid        (fir_valid),
        .fir_out          (fir_out)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [17:0] cf(input int i);
        case (i)
            0: return {6'h0, coef.tap4};
            1: return coef.center;
            2: return {6'h0, coef.tap6};
            3: return {6'h0, coef.tap7};
            default: return {6'h0, coef.tap8};
        endcase
    endfunction : cf

    // Readback clears the field MSB and all reserved bits
    function automatic logic [31:0] rb(input int i, input logic [17:0] f);
        return (i == 1) ? {15'h0, f[16:0]} : {21'h0, f[10:0]};
    endfunction : rb

    task automatic final_report();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [63:0] seen, input logic [63:0] want);
        checks++;
        if (seen !== want) begin
            bad_count++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : chk

    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge core_clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) begin
                bad_count++;
                final_report();
            end
            @(posedge core_clk);
        end
    endtask : wait_rdy

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
        chk(hresp, 64'h0);
    endtask : ahb

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [31:0] q;
        logic [31:0] w;
        logic        pv;
        logic [11:0] s;
        longint      pexp;
        longint      h [9];
        longint      tp [9];
        addr = '{{16'h0, `EQF_TAP4_ADDR}, {16'h0, `EQF_CENTER_ADDR}, {16'h0, `EQF_TAP6_ADDR},
                 {16'h0, `EQF_TAP7_ADDR}, {16'h0, `EQF_TAP8_ADDR}};
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            ahb(1'b0, addr[i], 32'h0, q);
            chk(q, 64'h0);
            chk(cf(i), 64'h0);
        end
        // All-ones corner first, then random words
        for (int p = 0; p < 3; p++) begin
            for (int i = 0; i < 5; i++) begin
                w = (p == 0) ? 32'hFFFF_FFFF : rnd();
                exp_f[i] = (i == 1) ? w[17:0] : {6'h0, w[11:0]};
                ahb(1'b1, addr[i], w, q);
                ahb(1'b0, addr[i], 32'h0, q);
                chk(q, rb(i, exp_f[i]));
                chk(cf(i), exp_f[i]);
            end
        end
        ahb(1'b1, {16'h0001, `EQF_TAP4_ADDR}, rnd(), q);
        ahb(1'b0, 32'h0000_1084, 32'h0, q);
        chk(q, 64'h0);
        ahb(1'b0, addr[0], 32'h0, q);
        chk(q, rb(0, exp_f[0]));
        w = rnd();
        tap9_coef <= w[11:0];
        lower_taps[0] <= w[23:12];
        tp[8] = $signed(w[11:0]);
        tp[0] = $signed(w[23:12]);
        w = rnd();
        lower_taps[1] <= w[11:0];
        lower_taps[2] <= w[23:12];
        tp[1] = $signed(w[11:0]);
        tp[2] = $signed(w[23:12]);
        tp[4] = $signed(exp_f[1]);
        for (int k = 0; k < 5; k++) begin
            if (k != 1) tp[(k == 0) ? 3 : k + 3] = $signed(exp_f[k][11:0]);
        end
        foreach (h[k]) h[k] = 0;
        pv = 1'b0;
        pexp = 0;
        // Sample stream, back to back at first, mode toggled every 128 cycles
        for (int n = 0; n < 400; n++) begin
            @(posedge core_clk);
            w = rnd();
            s = (n == 0) ? 12'h001 : w[11:0];
            single_chan_mode <= n[7];
            sample_valid <= w[31] | (n < 20);
            sample_in <= s;
            #1;
            chk(fir_valid, pv);
            chk({30'h0, fir_out}, {30'h0, pexp[33:0]});
            pv = w[31] | (n < 20);
            if (pv) begin
                for (int k = 8; k > 0; k--) h[k] = h[k - 1];
                h[0] = $signed(s);
                pexp = 0;
                foreach (h[k]) pexp += tp[k] * h[k];
            end
        end
        final_report();
    end
endmodule : testbench

`default_nettype wire
